// [common/ls_ldo_params.svh]
/*
 * Offsets, field positions, masks and per-variant reset values of the two
 * switch/regulator control registers.
 * Assumes inclusion by bare name from a design or bench file.
 */
`ifndef LS_LDO_PARAMS_SVH
`define LS_LDO_PARAMS_SVH

`define FIRST_CTRL_OFFSET 8'h14
`define SECOND_CTRL_OFFSET 8'h15
`define ROLE_BIT 5
`define CODE_MSB 4
`define CODE_LSB 0
`define WRITABLE_MASK 8'h3f
// per-variant reset bytes, variants a to d
`define FIRST_RESET_A 8'h06
`define FIRST_RESET_B 8'h3f
`define FIRST_RESET_C 8'h26
`define FIRST_RESET_D 8'h26
`define SECOND_RESET_A 8'h15
`define SECOND_RESET_B 8'h3f
`define SECOND_RESET_C 8'h3f
`define SECOND_RESET_D 8'h3f

`endif

// [common/ls_ldo_pkg.sv]
/*
 * Types for the switch/regulator control register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ls_ldo_pkg;
	// device variant selecting the reset values
	typedef enum logic [1:0] {
		VARIANT_A = 2'h0,
		VARIANT_B = 2'h1,
		VARIANT_C = 2'h2,
		VARIANT_D = 2'h3
	} variant_t;
	// output role held in the mode bit
	typedef enum logic {
		ROLE_LOAD_SWITCH = 1'h0,
		ROLE_REGULATOR = 1'h1
	} role_t;
endpackage : ls_ldo_pkg

// [src/ctrl_reg_byte.sv]
/*
 * One byte-wide switch/regulator control register: six writable bits,
 * two reserved bits that read zero.
 * Assumes write strobe already qualified by address and unlock.
 */
`timescale 1ns/1ps
`include "ls_ldo_params.svh"
module ctrl_reg_byte
	import ls_ldo_pkg::*;
#(
	parameter logic [7:0] RESET_VALUE = 8'h00
) (
	input wire logic sys_clk_i, // register clock
	input wire logic rstn_i, // synchronous reset, active low
	input wire logic wr_i, // accepted write strobe
	input wire logic [7:0] wdata_i, // write data
	output logic [7:0] value_o // stored byte, reserved bits zero
);
	logic [7:0] value_q;
	logic [7:0] value_d;

	// reserved bits masked on the way in, so they never hold a one
	assign value_d = wr_i ? (wdata_i & `WRITABLE_MASK) : value_q;
	assign value_o = value_q;

	// storage, reset restores the variant default
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			value_q <= RESET_VALUE & `WRITABLE_MASK;
		end else begin
			value_q <= value_d;
		end
	end
endmodule : ctrl_reg_byte

// [src/load_switch_ldo_config_regs.sv]
/*
 * Control register pair for two FET outputs, each a load switch or a
 * linear regulator with a 5-bit voltage code.
 * Holds the offset decode, the unlock gating of stores, the read select,
 * the per-variant reset choice and the level outputs that tell the analog
 * side which role each FET plays and which voltage code applies.
 * Enable bits, rail sequencing and the password state machine live
 * elsewhere; only the unlock result reaches this bank.
 * Assumes the serial register interface delivers one-cycle write strobes
 * with an 8-bit offset, and flags when the password unlock is satisfied
 * for the current write.
 * Assumes every input is synchronous to the register clock, so no
 * synchroniser is placed here.
 * Assumes reads have no side effects: the read data is a plain select of
 * the stored bytes, valid whenever the offset is steady.
 * Assumes the analog side heeds a voltage code only while the matching
 * role bit selects the regulator.
 */
// Summary of operation
// - first output bit 5: switch or regulator
// - first output bits 4-0: regulator voltage code
// - second output bit 5: switch or regulator
// - second output bits 4-0: regulator voltage code
// - first register bits 7-6 read zero
// - second register bits 7-6 read zero
// - second register writes need password unlock
// - second register sits at offset 0x15
// - first register at 0x14, also protected
`timescale 1ns/1ps
`include "ls_ldo_params.svh"
module load_switch_ldo_config_regs
	import ls_ldo_pkg::*;
#(
	parameter variant_t VARIANT = VARIANT_A
) (
	input wire logic sys_clk_i, // register clock, 125 MHz
	input wire logic rstn_i, // synchronous reset, active low
	input wire logic [7:0] addr_i, // register offset
	input wire logic wr_i, // write strobe, one cycle
	input wire logic [7:0] wdata_i, // write data
	input wire logic unlocked_i, // password unlock valid for this write
	output logic [7:0] rdata_o, // read data, zero when unmapped
	output logic hit_o, // offset belongs to this bank
	output role_t first_output_role_select_o, // first output role
	output logic [4:0] first_output_voltage_code_o, // first regulator code
	output role_t second_output_role_select_o, // second output role
	output logic [4:0] second_output_voltage_code_o // second regulator code
);
	// field geometry, taken once from the shared constants
	localparam int ROLE_POS = `ROLE_BIT;
	localparam int CODE_HI = `CODE_MSB;
	localparam int CODE_LO = `CODE_LSB;
	localparam int CODE_WIDTH = CODE_HI - CODE_LO + 1;
	localparam logic [7:0] KEEP_MASK = `WRITABLE_MASK; // role bit and code field
	localparam logic [7:0] RSVD_MASK = ~KEEP_MASK; // bits that always read zero
	localparam logic [7:0] ROLE_MASK = 8'h01 << ROLE_POS;
	localparam logic [7:0] CODE_MASK = ((8'h01 << CODE_WIDTH) - 8'h01) << CODE_LO;
	localparam logic [7:0] FIRST_OFFSET = `FIRST_CTRL_OFFSET;
	localparam logic [7:0] SECOND_OFFSET = `SECOND_CTRL_OFFSET;

	// reset byte of one register for one variant, worked out at elaboration
	function automatic logic [7:0] variant_reset(input variant_t variant, input logic pick_second);
		logic [7:0] value;
		value = 8'h00;
		if (pick_second) begin
			case (variant)
				VARIANT_A: begin
					value = `SECOND_RESET_A;
				end
				VARIANT_B: begin
					value = `SECOND_RESET_B;
				end
				VARIANT_C: begin
					value = `SECOND_RESET_C;
				end
				VARIANT_D: begin
					value = `SECOND_RESET_D;
				end
				default: begin
					value = 8'h00;
				end
			endcase
		end else begin
			case (variant)
				VARIANT_A: begin
					value = `FIRST_RESET_A;
				end
				VARIANT_B: begin
					value = `FIRST_RESET_B;
				end
				VARIANT_C: begin
					value = `FIRST_RESET_C;
				end
				VARIANT_D: begin
					value = `FIRST_RESET_D;
				end
				default: begin
					value = 8'h00;
				end
			endcase
		end
		return value;
	endfunction : variant_reset

	// variant reset bytes picked at elaboration
	localparam logic [7:0] FIRST_RESET = variant_reset(VARIANT, 1'b0);
	localparam logic [7:0] SECOND_RESET = variant_reset(VARIANT, 1'b1);

	// variant must name one of the four reset sets
	if (!(VARIANT inside {VARIANT_A, VARIANT_B, VARIANT_C, VARIANT_D})) begin : g_bad_variant
		$error("variant parameter names no reset set");
	end

	// code ports are five bits, so the field must be too
	if (CODE_WIDTH != 5) begin : g_bad_code_width
		$error("voltage code field is not five bits wide");
	end

	// code field has to sit inside the byte
	if (CODE_LO < 0 || CODE_HI > 7) begin : g_bad_code_place
		$error("voltage code field lies outside the byte");
	end

	// role bit has to sit inside the byte
	if (ROLE_POS < 0 || ROLE_POS > 7) begin : g_bad_role_place
		$error("role bit lies outside the byte");
	end

	// role output carries a single mode bit
	if ($bits(role_t) != 1) begin : g_bad_role_type
		$error("role type is not one bit wide");
	end

	// role bit and code field must not share a bit
	if ((ROLE_MASK & CODE_MASK) != 8'h00) begin : g_role_in_code
		$error("role bit overlaps the voltage code field");
	end

	// the store mask keeps exactly the two fields, nothing reserved
	if ((ROLE_MASK | CODE_MASK) != KEEP_MASK) begin : g_bad_keep_mask
		$error("writable mask differs from the role and code fields");
	end

	// two registers on one offset would both answer a read
	if (FIRST_OFFSET == SECOND_OFFSET) begin : g_same_offset
		$error("both control registers share one offset");
	end

	// reset bytes must leave the reserved bits clear
	if ((FIRST_RESET & RSVD_MASK) != 8'h00) begin : g_first_rsvd_reset
		$error("first reset byte sets a reserved bit");
	end

	if ((SECOND_RESET & RSVD_MASK) != 8'h00) begin : g_second_rsvd_reset
		$error("second reset byte sets a reserved bit");
	end

	// selects and store strobes
	logic first_sel;
	logic second_sel;
	logic write_open; // strobe with the unlock satisfied
	logic first_wr;
	logic second_wr;

	// stored bytes, read terms and field slices
	logic [7:0] first_value;
	logic [7:0] second_value;
	logic [7:0] first_rd;
	logic [7:0] second_rd;
	logic first_role_bit;
	logic [4:0] first_code;
	logic second_role_bit;
	logic [4:0] second_code;

	// address decode, one select per register
	assign first_sel = (addr_i == FIRST_OFFSET);
	assign second_sel = (addr_i == SECOND_OFFSET);
	assign hit_o = first_sel | second_sel;

	// one unlock flag gates both stores; a locked write is dropped silently
	assign write_open = wr_i & unlocked_i;
	assign first_wr = write_open & first_sel;
	assign second_wr = write_open & second_sel;

	// first register, reserved bits masked inside
	ctrl_reg_byte #(
		.RESET_VALUE(FIRST_RESET)
	) u_first (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.wr_i(first_wr),
		.wdata_i(wdata_i),
		.value_o(first_value)
	);

	// second register, same cell with its own reset byte
	ctrl_reg_byte #(
		.RESET_VALUE(SECOND_RESET)
	) u_second (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.wr_i(second_wr),
		.wdata_i(wdata_i),
		.value_o(second_value)
	);

	// and-or read select, so an unmapped offset reads zero
	assign first_rd = first_sel ? first_value : 8'h00;
	assign second_rd = second_sel ? second_value : 8'h00;
	assign rdata_o = first_rd | second_rd;

	// field slices of the stored bytes
	assign first_role_bit = first_value[ROLE_POS];
	assign first_code = first_value[CODE_HI:CODE_LO];
	assign second_role_bit = second_value[ROLE_POS];
	assign second_code = second_value[CODE_HI:CODE_LO];

	// level outputs straight from the flops: they move only on a store or reset
	assign first_output_role_select_o = role_t'(first_role_bit);
	assign first_output_voltage_code_o = first_code;
	assign second_output_role_select_o = role_t'(second_role_bit);
	assign second_output_voltage_code_o = second_code;
endmodule : load_switch_ldo_config_regs

// [testbench/ls_ldo_properties.sv]
/* Checker for the control register pair.
   Assumes the top module's ports, one clock. */
`timescale 1ns/1ps
module ls_ldo_checker
	import ls_ldo_pkg::*;
(
	input wire logic sys_clk_i, // clock
	input wire logic rstn_i, // reset
	input wire logic [7:0] addr_i, // offset
	input wire logic wr_i, // write
	input wire logic [7:0] wdata_i, // data
	input wire logic unlocked_i, // unlock
	input wire logic [7:0] rdata_o, // read
	input wire logic hit_o, // mapped
	input wire role_t first_output_role_select_o, // role
	input wire logic [4:0] first_output_voltage_code_o, // code
	input wire role_t second_output_role_select_o, // role
	input wire logic [4:0] second_output_voltage_code_o // code
);
	// short names; acc is a write with the unlock satisfied at any offset, hit marks a mapped offset
	wire [5:0] f1 = {first_output_role_select_o, first_output_voltage_code_o};
	wire [5:0] f2 = {second_output_role_select_o, second_output_voltage_code_o};
	wire [11:0] both = {f1, f2};
	wire acc = wr_i && unlocked_i;
	wire hit = addr_i == 8'h14 || addr_i == 8'h15;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	// a reset edge reloads defaults, so only edges sampled out of reset count
	role1_write_a: assert property (rstn_i && acc && addr_i == 8'h14 |=> f1[5] == $past(wdata_i[5]))
		else $error("first role not written");
	code1_write_a: assert property (rstn_i && acc && addr_i == 8'h14 |=> f1[4:0] == $past(wdata_i[4:0]))
		else $error("first code not written");
	role2_write_a: assert property (rstn_i && acc && addr_i == 8'h15 |=> f2[5] == $past(wdata_i[5]))
		else $error("second role not written");
	code2_write_a: assert property (rstn_i && acc && addr_i == 8'h15 |=> f2[4:0] == $past(wdata_i[4:0]))
		else $error("second code not written");
	refused_hold_a: assert property (rstn_i && !(acc && hit) |=> $stable(both))
		else $error("value moved without write");
	rsvd_zero_a: assert property (rdata_o[7:6] == 2'h0)
		else $error("reserved bits set");
	read_back_a: assert property (hit |-> rdata_o == {2'h0, addr_i[0] ? f2 : f1})
		else $error("read value wrong");
	map_decode_a: assert property (hit_o == hit && (hit || rdata_o == 8'h00))
		else $error("decode wrong");
endmodule : ls_ldo_checker
bind load_switch_ldo_config_regs ls_ldo_checker chk (.*);

// [testbench/load_switch_ldo_config_regs_test.sv]
/* Self-checking bench, variant a.
   Assumes design and checker compiled first. */
`timescale 1ns/1ps
`include "ls_ldo_params.svh"
module load_switch_ldo_config_regs_test
	import ls_ldo_pkg::*;
;
	logic sys_clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, unlocked_i = 1'b0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
	wire [7:0] rdata_o;
	wire hit_o, r1, r2;
	wire [4:0] c1, c2;
	int num_errors = 0, checks = 0, cycles = 0;
	load_switch_ldo_config_regs #(.VARIANT(VARIANT_A)) uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.addr_i(addr_i), .wr_i(wr_i), .wdata_i(wdata_i), .unlocked_i(unlocked_i), .rdata_o(rdata_o),
		.hit_o(hit_o), .first_output_role_select_o(r1), .first_output_voltage_code_o(c1),
		.second_output_role_select_o(r2), .second_output_voltage_code_o(c2));
	// clock, and a cycle ceiling against hangs
	always #4 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 500) begin
			num_errors++;
			stop_test();
		end
	end
	task stop_test();
		if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, g, e);
		end
	endtask : chk
	// one write strobe, held to the edge that takes it, then released
	task wr(input logic [7:0] a, input logic [7:0] d, input logic u);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		unlocked_i <= u;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask : wr
	// read is combinational, so sample mid-cycle
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		addr_i <= a;
		@(negedge sys_clk_i);
		chk(rdata_o, e);
	endtask : rd
	task t_defaults();
		rd(8'h14, `FIRST_RESET_A);
		chk({2'h0, r1, c1}, `FIRST_RESET_A);
		rd(8'h15, `SECOND_RESET_A);
		chk({7'h00, hit_o}, 8'h01);
		chk({2'h0, r2, c2}, `SECOND_RESET_A);
	endtask : t_defaults
	task t_writes();
		wr(8'h14, 8'hff, 1'b1);
		wr(8'h15, 8'hc0, 1'b1);
		rd(8'h14, 8'h3f);
		chk({2'h0, r1, c1}, 8'h3f);
		rd(8'h15, 8'h00);
		wr(8'h15, 8'h2a, 1'b1);
		// outputs settle after the taking edge, so look mid-cycle
		@(negedge sys_clk_i);
		chk({2'h0, r2, c2}, 8'h2a);
	endtask : t_writes
	// locked writes and a neighbour offset change nothing
	task t_refused();
		wr(8'h15, 8'h3f, 1'b0);
		rd(8'h15, 8'h2a);
		chk({2'h0, r2, c2}, 8'h2a);
		wr(8'h14, 8'h00, 1'b0);
		rd(8'h14, 8'h3f);
		wr(8'h16, 8'h00, 1'b1);
		rd(8'h16, 8'h00);
		chk({7'h00, hit_o}, 8'h00);
		rd(8'h14, 8'h3f);
		rd(8'h15, 8'h2a);
	endtask : t_refused
	initial begin
		repeat (20) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		t_defaults();
		t_writes();
		t_refused();
		@(posedge sys_clk_i);
		rstn_i <= 1'b0;
		@(posedge sys_clk_i);
		rstn_i <= 1'b1;
		t_defaults();
		stop_test();
	end
endmodule : load_switch_ldo_config_regs_test
